// *** logic/pio_regs.svh ***
// Register offsets, field positions, reset values and codes of the port block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PIO_REGS_SVH
`define PIO_REGS_SVH

// Byte addresses of the registers on the AXI4-Lite slave.
`define PIO_A_LATCH_OFS 8'h00
`define PIO_A_DIR_OFS 8'h04
`define PIO_A_INPUT_OFS 8'h08
`define PIO_A_DRIVE_OFS 8'h0C
`define PIO_C_LATCH_OFS 8'h10
`define PIO_C_DIR_OFS 8'h14
`define PIO_C_INPUT_OFS 8'h18
`define PIO_C_DRIVE_OFS 8'h1C
`define PIO_D_LATCH_OFS 8'h20
`define PIO_D_DIR_OFS 8'h24
`define PIO_D_INPUT_OFS 8'h28
`define PIO_D_DRIVE_OFS 8'h2C
`define PIO_CTRL_OFS 8'h30

// Field positions of the function control register.
`define PIO_CTRL_SPI_EN_BIT 0
`define PIO_CTRL_IDI_EN_BIT 1
`define PIO_CTRL_IDI_4BIT_BIT 2

// Pins handed to peripherals when their function is on.
`define PIO_A_SPI_MASK 6'h0F
`define PIO_D_WIDE_MASK 8'hFF
`define PIO_D_NARROW_MASK 8'h0F

// Reset values.
`define PIO_RST_PORT_A 6'h00
`define PIO_RST_PORT_C 2'h0
`define PIO_RST_PORT_D 8'h00
`define PIO_RST_CTRL 3'h0

// AXI response codes.
`define PIO_RESP_OKAY 2'h0
`define PIO_RESP_SLVERR 2'h2

`endif

// *** logic/pio_pkg.sv ***
// Types shared by the port block: the packed state of the top module.
// Assumes the register header sits next to it.
`include "pio_regs.svh"

package pio_pkg;

  // Complete state of the top module.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [7:0] w_data;
    logic w_en;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [5:0] a_latch;
    logic [5:0] a_dir;
    logic [5:0] a_rdr;
    logic [1:0] c_latch;
    logic [1:0] c_dir;
    logic [1:0] c_rdr;
    logic [7:0] d_latch;
    logic [7:0] d_dir;
    logic [7:0] d_rdr;
    logic spi_en;
    logic idi_en;
    logic idi_4bit;
    logic [5:0] pa_out;
    logic [5:0] pa_oe;
    logic [5:0] pa_low_drive;
    logic [1:0] pc_out;
    logic [1:0] pc_oe;
    logic [1:0] pc_low_drive;
    logic [1:0] pc_pulldown;
    logic [7:0] pd_out;
    logic [7:0] pd_oe;
    logic [7:0] pd_low_drive;
    logic [7:0] pd_pulldown;
  } pio_state_t;

endpackage

// *** logic/pio_sync.sv ***
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs may change at any time relative to aclk.
`timescale 1ns/1ps

module pio_sync #(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Raw and synchronised levels.
  input wire logic [W-1:0] raw,
  output logic [W-1:0] synced
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } pio_sync_t;

  pio_sync_t sync_ff;
  pio_sync_t nxt_sync;

  // The first stage is read by the second stage only.
  always_comb begin
    nxt_sync.meta = raw;
    nxt_sync.stable = sync_ff.meta;
  end

  // Both stages clear on reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_ff <= '0;
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  assign synced = sync_ff.stable;

endmodule // pio_sync

// *** logic/pio_pin_cell.sv ***
// Pin function mux for one port: picks latch or peripheral drive.
// Assumes take marks pins owned by a peripheral; purely combinational.
`timescale 1ns/1ps

module pio_pin_cell #(
  parameter int W = 8
) (
  // Software registers of the port.
  input wire logic [W-1:0] latch,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] rdr,
  // Peripheral ownership and drive.
  input wire logic [W-1:0] take,
  input wire logic [W-1:0] per_out,
  input wire logic [W-1:0] per_oe,
  input wire logic [W-1:0] sync_in,
  // Resulting pin controls and readback.
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe,
  output logic [W-1:0] low_drive,
  output logic [W-1:0] per_pull,
  output logic [W-1:0] rd_latch
);

  // The peripheral overrides latch and direction on pins it owns.
  assign pin_out = (take & per_out) | (~take & latch);
  assign pin_oe = (take & per_oe) | (~take & dir);
  // Reduced drive only matters for a driven pin.
  assign low_drive = rdr & pin_oe;
  // Peripheral-owned inputs get a pull-down.
  assign per_pull = take & ~per_oe;
  // Latch address returns the pin when input, the latch when output.
  assign rd_latch = (dir & latch) | (~dir & sync_in);

endmodule // pio_pin_cell

// *** logic/pio_top.sv ***
// Port A, C and D pin logic with an AXI4-Lite register slave.
// Assumes asynchronous pins outside and an SPI and inter-die link inside.
//
// Summary of operation
// - Latch drives pin only as GPIO output
// - Direction 0: latch address reads pin
// - Direction 1: latch address reads latch
// - Peripheral ownership overrides direction bits
// - Input view always reads synchronised pin
// - Drive select sets output driver strength
// - Port A six pins, SPI on 3-0
// - Port C: interrupt in, clock out
// - Pull-down on C1 as interrupt input
// - Interrupt synchronised; stop mode bypass wakes
// - Port D internal: GPIO or data
// - Four-bit mode frees port D 7-4
// - Pull-downs on port D data inputs
// - Direction 1 output, 0 high-Z input
// - Drive 1 one-sixth strength, 0 full
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pio_regs.svh"

module pio_top
  import pio_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address.
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  // AXI4-Lite write data.
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response.
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address.
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  // AXI4-Lite read data.
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Port A pins.
  input wire logic [5:0] port_a_pins_in,
  output logic [5:0] port_a_pins_out,
  output logic [5:0] port_a_pins_oe,
  output logic [5:0] port_a_low_drive,
  // Port C pins.
  input wire logic [1:0] port_c_pins_in,
  output logic [1:0] port_c_pins_out,
  output logic [1:0] port_c_pins_oe,
  output logic [1:0] port_c_low_drive,
  output logic [1:0] port_c_pulldown,
  // Port D lines toward the companion die.
  input wire logic [7:0] port_d_pins_in,
  output logic [7:0] port_d_pins_out,
  output logic [7:0] port_d_pins_oe,
  output logic [7:0] port_d_low_drive,
  output logic [7:0] port_d_pulldown,
  // SPI side.
  input wire logic [3:0] spi_pin_out,
  input wire logic [3:0] spi_pin_oe,
  output logic [3:0] spi_pin_in,
  // Inter-die interface side.
  input wire logic stop_mode,
  input wire logic idi_clk_out,
  input wire logic [7:0] idi_data_out,
  input wire logic [7:0] idi_data_oe,
  output logic [7:0] idi_data_in,
  output logic idi_int_sync,
  output logic idi_int_wake
);

  pio_state_t state_ff;
  pio_state_t nxt_state;

  logic [15:0] sync_all;
  logic [5:0] a_sync;
  logic [1:0] c_sync;
  logic [7:0] d_sync;
  logic [5:0] a_take;
  logic [1:0] c_take;
  logic [7:0] d_take;
  logic [1:0] c_per_out;
  logic [1:0] c_per_oe;
  logic [5:0] a_out;
  logic [5:0] a_oe;
  logic [5:0] a_low;
  logic [5:0] a_rd;
  logic [1:0] c_out;
  logic [1:0] c_oe;
  logic [1:0] c_low;
  logic [1:0] c_pull;
  logic [1:0] c_rd;
  logic [7:0] d_out;
  logic [7:0] d_oe;
  logic [7:0] d_low;
  logic [7:0] d_pull;
  logic [7:0] d_rd;

  // Every pin input crosses two flops before any readback or peripheral, except the raw C1 wake path.
  pio_sync #(
    .W(16)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw({port_d_pins_in, port_c_pins_in, port_a_pins_in}),
    .synced(sync_all)
  );

  assign a_sync = sync_all[5:0];
  assign c_sync = sync_all[7:6];
  assign d_sync = sync_all[15:8];

  // Pin ownership: SPI takes A3-0 only, never A5-4.
  assign a_take = state_ff.spi_en ? `PIO_A_SPI_MASK : 6'h00;
  // The link takes both C pins: C1 interrupt input, C0 clock output.
  assign c_take = state_ff.idi_en ? 2'h3 : 2'h0;
  assign c_per_out = {1'b0, idi_clk_out};
  assign c_per_oe = 2'h1;
  // Four-bit mode leaves D7-4 to general-purpose use.
  assign d_take = !state_ff.idi_en ? 8'h00 :
    (state_ff.idi_4bit ? `PIO_D_NARROW_MASK : `PIO_D_WIDE_MASK);

  // Port A mux.
  pio_pin_cell #(
    .W(6)
  ) u_cell_a (
    .latch(state_ff.a_latch),
    .dir(state_ff.a_dir),
    .rdr(state_ff.a_rdr),
    .take(a_take),
    .per_out({2'h0, spi_pin_out}),
    .per_oe({2'h0, spi_pin_oe}),
    .sync_in(a_sync),
    .pin_out(a_out),
    .pin_oe(a_oe),
    .low_drive(a_low),
    .per_pull(),
    .rd_latch(a_rd)
  );

  // Port C mux.
  pio_pin_cell #(
    .W(2)
  ) u_cell_c (
    .latch(state_ff.c_latch),
    .dir(state_ff.c_dir),
    .rdr(state_ff.c_rdr),
    .take(c_take),
    .per_out(c_per_out),
    .per_oe(c_per_oe),
    .sync_in(c_sync),
    .pin_out(c_out),
    .pin_oe(c_oe),
    .low_drive(c_low),
    .per_pull(c_pull),
    .rd_latch(c_rd)
  );

  // Port D mux.
  pio_pin_cell #(
    .W(8)
  ) u_cell_d (
    .latch(state_ff.d_latch),
    .dir(state_ff.d_dir),
    .rdr(state_ff.d_rdr),
    .take(d_take),
    .per_out(idi_data_out),
    .per_oe(idi_data_oe),
    .sync_in(d_sync),
    .pin_out(d_out),
    .pin_oe(d_oe),
    .low_drive(d_low),
    .per_pull(d_pull),
    .rd_latch(d_rd)
  );

  // Read multiplexer; unmapped addresses read zero with an error.
  function automatic logic [32:0] pio_read(input logic [7:0] addr);
    logic [32:0] r;
    r = 33'h0_0000_0000;
    unique case (addr)
      `PIO_A_LATCH_OFS: r[5:0] = a_rd;
      `PIO_A_DIR_OFS: r[5:0] = state_ff.a_dir;
      `PIO_A_INPUT_OFS: r[5:0] = a_sync;
      `PIO_A_DRIVE_OFS: r[5:0] = state_ff.a_rdr;
      `PIO_C_LATCH_OFS: r[1:0] = c_rd;
      `PIO_C_DIR_OFS: r[1:0] = state_ff.c_dir;
      `PIO_C_INPUT_OFS: r[1:0] = c_sync;
      `PIO_C_DRIVE_OFS: r[1:0] = state_ff.c_rdr;
      `PIO_D_LATCH_OFS: r[7:0] = d_rd;
      `PIO_D_DIR_OFS: r[7:0] = state_ff.d_dir;
      `PIO_D_INPUT_OFS: r[7:0] = d_sync;
      `PIO_D_DRIVE_OFS: r[7:0] = state_ff.d_rdr;
      `PIO_CTRL_OFS: begin
        r[`PIO_CTRL_SPI_EN_BIT] = state_ff.spi_en;
        r[`PIO_CTRL_IDI_EN_BIT] = state_ff.idi_en;
        r[`PIO_CTRL_IDI_4BIT_BIT] = state_ff.idi_4bit;
      end
      default: r[32] = 1'b1;
    endcase
    return r;
  endfunction

  // Next state: bus slave, register writes and pin outputs.
  always_comb begin
    logic [32:0] rd;
    logic [7:0] wd;
    rd = pio_read(araddr);
    wd = state_ff.w_data;
    nxt_state = state_ff;
    // Address and data are taken in either order and held.
    if (awvalid && state_ff.awready) begin
      nxt_state.aw_hold = 1'b1;
      nxt_state.aw_addr = awaddr;
    end
    if (wvalid && state_ff.wready) begin
      nxt_state.w_hold = 1'b1;
      nxt_state.w_data = wdata[7:0];
      nxt_state.w_en = wstrb[0];
    end
    if (state_ff.bvalid && bready) begin
      nxt_state.bvalid = 1'b0;
    end
    // Both halves present: perform the write and raise the response.
    if (state_ff.aw_hold && state_ff.w_hold && !state_ff.bvalid) begin
      nxt_state.aw_hold = 1'b0;
      nxt_state.w_hold = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = `PIO_RESP_OKAY;
      unique case (state_ff.aw_addr)
        `PIO_A_LATCH_OFS: begin
          if (state_ff.w_en) nxt_state.a_latch = wd[5:0];
        end
        `PIO_A_DIR_OFS: begin
          if (state_ff.w_en) nxt_state.a_dir = wd[5:0];
        end
        `PIO_A_DRIVE_OFS: begin
          if (state_ff.w_en) nxt_state.a_rdr = wd[5:0];
        end
        `PIO_C_LATCH_OFS: begin
          if (state_ff.w_en) nxt_state.c_latch = wd[1:0];
        end
        `PIO_C_DIR_OFS: begin
          if (state_ff.w_en) nxt_state.c_dir = wd[1:0];
        end
        `PIO_C_DRIVE_OFS: begin
          if (state_ff.w_en) nxt_state.c_rdr = wd[1:0];
        end
        `PIO_D_LATCH_OFS: begin
          if (state_ff.w_en) nxt_state.d_latch = wd;
        end
        `PIO_D_DIR_OFS: begin
          if (state_ff.w_en) nxt_state.d_dir = wd;
        end
        `PIO_D_DRIVE_OFS: begin
          if (state_ff.w_en) nxt_state.d_rdr = wd;
        end
        `PIO_CTRL_OFS: begin
          if (state_ff.w_en) begin
            nxt_state.spi_en = wd[`PIO_CTRL_SPI_EN_BIT];
            nxt_state.idi_en = wd[`PIO_CTRL_IDI_EN_BIT];
            nxt_state.idi_4bit = wd[`PIO_CTRL_IDI_4BIT_BIT];
          end
        end
        // Input views accept and ignore writes.
        `PIO_A_INPUT_OFS, `PIO_C_INPUT_OFS, `PIO_D_INPUT_OFS: begin
        end
        default: nxt_state.bresp = `PIO_RESP_SLVERR;
      endcase
    end
    nxt_state.awready = !nxt_state.aw_hold && !nxt_state.bvalid;
    nxt_state.wready = !nxt_state.w_hold && !nxt_state.bvalid;
    // Read: data registered at the same edge that takes the address.
    if (state_ff.rvalid && rready) begin
      nxt_state.rvalid = 1'b0;
    end
    if (arvalid && state_ff.arready) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rdata = rd[31:0];
      nxt_state.rresp = rd[32] ? `PIO_RESP_SLVERR : `PIO_RESP_OKAY;
    end
    nxt_state.arready = !nxt_state.rvalid;
    // Pin controls are registered so every pin output leaves a flop.
    nxt_state.pa_out = a_out;
    nxt_state.pa_oe = a_oe;
    nxt_state.pa_low_drive = a_low;
    nxt_state.pc_out = c_out;
    nxt_state.pc_oe = c_oe;
    nxt_state.pc_low_drive = c_low;
    nxt_state.pc_pulldown = c_pull;
    nxt_state.pd_out = d_out;
    nxt_state.pd_oe = d_oe;
    nxt_state.pd_low_drive = d_low;
    nxt_state.pd_pulldown = d_pull;
  end

  // State register; ready lines come up one cycle after reset release.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= '0;
      state_ff.a_latch <= `PIO_RST_PORT_A;
      state_ff.c_latch <= `PIO_RST_PORT_C;
      state_ff.d_latch <= `PIO_RST_PORT_D;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Bus outputs.
  assign awready = state_ff.awready;
  assign wready = state_ff.wready;
  assign bvalid = state_ff.bvalid;
  assign bresp = state_ff.bresp;
  assign arready = state_ff.arready;
  assign rvalid = state_ff.rvalid;
  assign rdata = state_ff.rdata;
  assign rresp = state_ff.rresp;

  // Pin outputs.
  assign port_a_pins_out = state_ff.pa_out;
  assign port_a_pins_oe = state_ff.pa_oe;
  assign port_a_low_drive = state_ff.pa_low_drive;
  assign port_c_pins_out = state_ff.pc_out;
  assign port_c_pins_oe = state_ff.pc_oe;
  assign port_c_low_drive = state_ff.pc_low_drive;
  assign port_c_pulldown = state_ff.pc_pulldown;
  assign port_d_pins_out = state_ff.pd_out;
  assign port_d_pins_oe = state_ff.pd_oe;
  assign port_d_low_drive = state_ff.pd_low_drive;
  assign port_d_pulldown = state_ff.pd_pulldown;

  // Peripheral inputs come from the synchroniser flops.
  assign spi_pin_in = a_sync[3:0];
  assign idi_data_in = d_sync;
  assign idi_int_sync = c_sync[1] & state_ff.idi_en;
  // In stop mode the clock may halt, so the wake path skips the flops.
  assign idi_int_wake = stop_mode & state_ff.idi_en & port_c_pins_in[1];

endmodule // pio_top

// *** verification/pio_top_chk.sv ***
// Checker of the port block: pin and bus relations at its ports.
// Assumes a bind into pio_top, whose port names match these.
`timescale 1ns/1ps
module pio_top_chk (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes.
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  // Pins and link.
  input wire logic [5:0] port_a_pins_in,
  input wire logic [5:0] port_a_pins_oe,
  input wire logic [5:0] port_a_low_drive,
  input wire logic [1:0] port_c_pins_in,
  input wire logic [1:0] port_c_pins_oe,
  input wire logic [1:0] port_c_pulldown,
  input wire logic [7:0] port_d_pins_in,
  input wire logic [7:0] port_d_pins_oe,
  input wire logic [7:0] port_d_low_drive,
  input wire logic [7:0] port_d_pulldown,
  input wire logic [3:0] spi_pin_in,
  input wire logic stop_mode,
  input wire logic [7:0] idi_data_in,
  input wire logic idi_int_sync,
  input wire logic idi_int_wake
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Handshakes that start a transfer.
  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_take;
    arvalid && arready;
  endsequence
  // Answers come within the stated cycles.
  write_answer_a: assert property (wr_take |-> ##[1:3] bvalid)
    else $error("write response late");
  read_answer_a: assert property (rd_take |-> ##[1:2] rvalid)
    else $error("read data late");
  // Reduced drive only ever reaches a driven pin of port A or D.
  drive_gate_a: assert property (
    ((port_a_low_drive & ~port_a_pins_oe) == 6'h00) &&
    ((port_d_low_drive & ~port_d_pins_oe) == 8'h00))
    else $error("reduced drive on an input pin");
  // Pull-downs sit on undriven link inputs only.
  c_pull_a: assert property (port_c_pulldown[1] |->
    !port_c_pins_oe[1] && !port_c_pulldown[0])
    else $error("bad pull-down on port C");
  d_pull_a: assert property (
    (port_d_pulldown & port_d_pins_oe) == 8'h00)
    else $error("pull-down on a driven port D pin");
  // The wake bypass needs stop mode and a high raw pin.
  wake_path_a: assert property (idi_int_wake |->
    stop_mode && port_c_pins_in[1])
    else $error("wake without cause");
  int_sync_a: assert property (idi_int_sync |->
    $past(port_c_pins_in[1], 2))
    else $error("interrupt not from synchronised pin");
  // Inputs are seen through two flops.
  spi_sync_a: assert property ($past(aresetn) &&
    $past(aresetn, 2) |-> spi_pin_in == $past(port_a_pins_in[3:0], 2))
    else $error("SPI input not two cycles behind pin");
  data_sync_a: assert property ($past(aresetn) &&
    $past(aresetn, 2) |-> idi_data_in == $past(port_d_pins_in, 2))
    else $error("link input not two cycles behind pin");
endmodule // pio_top_chk
bind pio_top pio_top_chk pio_top_chk_inst (.*);

// *** verification/pio_pin_model.sv ***
// Far side of the pins: pads, pulls and the companion die's drivers.
// Assumes the bench sets ext and ext_en as the outside world.
`timescale 1ns/1ps
module pio_pin_model #(
  parameter int W = 16
) (
  // Pin controls from the block.
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] pull,
  // Outside drivers.
  input wire logic [W-1:0] ext,
  input wire logic [W-1:0] ext_en,
  // Resolved pin levels.
  output logic [W-1:0] pin_in
);
  // Block drive wins, then an outside driver, then the pull-down; a
  // floating pin shows the inverse of the block's value, never a hold.
  assign pin_in = (oe & out) | (~oe & ext_en & ext) |
                  (~oe & ~ext_en & ~pull & ~out);
endmodule // pio_pin_model

// *** verification/test_port_pin_io_control.sv ***
// Self-checking bench of the port block with its pin model.
// Assumes the design, package and checker are compiled first.
`timescale 1ns/1ps
`include "pio_regs.svh"
module test_port_pin_io_control;
  // Design inputs.
  logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0;
  logic arvalid = '0, rready = '0, stop_mode = '0, idi_clk_out = '0;
  logic [7:0] awaddr = '0, araddr = '0, idi_data_out = '0, idi_data_oe = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0, spi_pin_out = '0, spi_pin_oe = '0;
  // Design outputs and pins.
  logic awready, wready, bvalid, arready, rvalid, idi_int_sync, idi_int_wake;
  logic [1:0] bresp, rresp, port_c_pins_out, port_c_pins_oe;
  logic [1:0] port_c_low_drive, port_c_pulldown;
  logic [31:0] rdata;
  logic [5:0] port_a_pins_out, port_a_pins_oe, port_a_low_drive;
  logic [7:0] port_d_pins_out, port_d_pins_oe, port_d_low_drive;
  logic [7:0] port_d_pulldown, idi_data_in;
  logic [3:0] spi_pin_in;
  wire [5:0] port_a_pins_in;
  wire [1:0] port_c_pins_in;
  wire [7:0] port_d_pins_in;
  // Bench state.
  logic [15:0] ext = '0, ext_en = '1;
  logic [31:0] q_s;
  logic [1:0] r_s;
  int failures = 0, n_compared = 0;
  // Clock of 25 ns.
  always #12.5 aclk = ~aclk;
  pio_top pio_top_inst (.*);
  pio_pin_model #(.W(16)) pio_pin_model_inst (
    .out({port_d_pins_out, port_c_pins_out, port_a_pins_out}),
    .oe({port_d_pins_oe, port_c_pins_oe, port_a_pins_oe}),
    .pull({port_d_pulldown, port_c_pulldown, 6'h00}),
    .ext(ext),
    .ext_en(ext_en),
    .pin_in({port_d_pins_in, port_c_pins_in, port_a_pins_in})
  );
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic give_verdict;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Waits a fixed count of cycles and settles at a falling edge.
  task automatic tick(input int n);
    repeat (n) @(negedge aclk);
  endtask
  // One bus transfer; each channel is released at the edge taking it.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    int n;
    logic ta, tw, td;
    td = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'hF;
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    for (n = 0; n < 40 && !td; n++) begin
      @(negedge aclk);
      ta = (awvalid && awready) || (arvalid && arready);
      tw = wvalid && wready;
      td = (bvalid && bready) || (rvalid && rready);
      q_s = rdata;
      r_s = w ? bresp : rresp;
      @(posedge aclk);
      if (ta) begin
        awvalid <= 1'h0;
        arvalid <= 1'h0;
      end
      if (tw) wvalid <= 1'h0;
      if (td) begin
        bready <= 1'h0;
        rready <= 1'h0;
      end
    end
    if (!td) begin
      failures++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'h0, a, 8'h00);
  endtask
  // Reset values, the read-only view and an unmapped place.
  task automatic t_reset;
    rd(`PIO_A_DIR_OFS);
    chk("dir", q_s, 32'h0);
    chk("a oe", port_a_pins_oe, 32'h0);
    wr(`PIO_A_INPUT_OFS, 8'h3F);
    chk("resp", r_s, 32'h0);
    rd(`PIO_A_INPUT_OFS);
    chk("view", q_s, 32'h0);
    rd(8'h34);
    chk("unmapped", q_s, 32'h0);
    chk("unmapped resp", r_s, 32'h2);
  endtask
  // Latch loaded first, then outputs enabled, then drive strength.
  task automatic t_out;
    wr(`PIO_A_LATCH_OFS, 8'h2A);
    tick(2);
    chk("a oe", port_a_pins_oe, 32'h0);
    wr(`PIO_A_DIR_OFS, 8'h3F);
    wr(`PIO_A_DRIVE_OFS, 8'h05);
    tick(2);
    chk("a out", port_a_pins_out, 32'h2A);
    chk("a oe", port_a_pins_oe, 32'h3F);
    chk("a drive", port_a_low_drive, 32'h05);
    wr(`PIO_A_DIR_OFS, 8'h3C);
    tick(2);
    chk("a drive", port_a_low_drive, 32'h04);
  endtask
  // Mixed directions: the latch address shows pins on input bits.
  task automatic t_in;
    @(posedge aclk);
    ext <= 16'h0013;
    tick(4);
    rd(`PIO_A_LATCH_OFS);
    chk("latch rd", q_s, 32'h2B);
    rd(`PIO_A_INPUT_OFS);
    chk("view", q_s, 32'h2B);
  endtask
  // SPI takes pins 3 to 0 and overrides their direction bits.
  task automatic t_spi;
    wr(`PIO_CTRL_OFS, 8'h01);
    @(posedge aclk);
    spi_pin_out <= 4'h5;
    spi_pin_oe <= 4'hF;
    tick(4);
    chk("a out", port_a_pins_out, 32'h25);
    chk("a oe", port_a_pins_oe, 32'h3F);
    chk("spi in", spi_pin_in, 32'h5);
    rd(`PIO_A_LATCH_OFS);
    chk("latch rd", q_s, 32'h29);
    rd(`PIO_A_INPUT_OFS);
    chk("view", q_s, 32'h25);
    @(posedge aclk);
    spi_pin_oe <= 4'h0;
    tick(2);
    chk("a oe", port_a_pins_oe, 32'h30);
    wr(`PIO_CTRL_OFS, 8'h00);
  endtask
  // Port C as plain outputs: latch, direction, drive and both views.
  task automatic t_port_c;
    wr(`PIO_C_LATCH_OFS, 8'h02);
    wr(`PIO_C_DIR_OFS, 8'h03);
    wr(`PIO_C_DRIVE_OFS, 8'h01);
    tick(2);
    chk("c out", port_c_pins_out, 32'h2);
    chk("c oe", port_c_pins_oe, 32'h3);
    chk("c drive", port_c_low_drive, 32'h1);
    rd(`PIO_C_LATCH_OFS);
    chk("c latch rd", q_s, 32'h2);
    rd(`PIO_C_INPUT_OFS);
    chk("c view", q_s, 32'h2);
  endtask
  // Link in eight-bit mode: clock, interrupt, wake and data lines.
  task automatic t_link;
    wr(`PIO_CTRL_OFS, 8'h02);
    @(posedge aclk);
    idi_clk_out <= 1'h1;
    ext <= 16'hA080;
    ext_en <= 16'hF0FF;
    idi_data_out <= 8'h05;
    idi_data_oe <= 8'h0F;
    tick(4);
    chk("c oe", port_c_pins_oe, 32'h1);
    chk("c clk", port_c_pins_out[0], 32'h1);
    chk("c pull", port_c_pulldown, 32'h2);
    chk("int", idi_int_sync, 32'h1);
    chk("wake", idi_int_wake, 32'h0);
    chk("d oe", port_d_pins_oe, 32'h0F);
    chk("d out", port_d_pins_out, 32'h05);
    chk("d pull", port_d_pulldown, 32'hF0);
    chk("d in", idi_data_in, 32'hA5);
    @(posedge aclk);
    stop_mode <= 1'h1;
    tick(1);
    chk("wake", idi_int_wake, 32'h1);
    @(posedge aclk);
    ext_en <= 16'hF07F;
    tick(1);
    chk("wake", idi_int_wake, 32'h0);
    @(posedge aclk);
    stop_mode <= 1'h0;
    tick(2);
    chk("int", idi_int_sync, 32'h0);
  endtask
  // Four-bit mode hands port D pins 7 to 4 back to the registers.
  task automatic t_narrow;
    wr(`PIO_D_LATCH_OFS, 8'h30);
    wr(`PIO_D_DIR_OFS, 8'hF0);
    wr(`PIO_D_DRIVE_OFS, 8'h90);
    tick(2);
    chk("d oe", port_d_pins_oe, 32'h0F);
    chk("d drive", port_d_low_drive, 32'h00);
    wr(`PIO_CTRL_OFS, 8'h06);
    tick(2);
    chk("d oe", port_d_pins_oe, 32'hFF);
    chk("d drive", port_d_low_drive, 32'h90);
    chk("d out", port_d_pins_out, 32'h35);
    chk("d pull", port_d_pulldown, 32'h00);
    @(posedge aclk);
    idi_data_oe <= 8'h00;
    tick(2);
    chk("d pull", port_d_pulldown, 32'h0F);
    tick(2);
    rd(`PIO_D_INPUT_OFS);
    chk("d view", q_s, 32'h30);
    rd(`PIO_CTRL_OFS);
    chk("ctrl", q_s, 32'h6);
  endtask
  // Main sequence.
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_out();
    t_in();
    t_spi();
    t_port_c();
    t_link();
    t_narrow();
    give_verdict();
  end
endmodule // test_port_pin_io_control
